// >>> common/mid_pkg.sv
// Shared constants and types for the instruction decoder block
package mid_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the Avalon slave)
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_INSTR = 4'h0;
	localparam logic [3:0] OFF_CONFIG = 4'h4;
	localparam logic [3:0] OFF_FIELDS = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;
	localparam logic CFG_PSA_RESET = 1'h1;
	localparam int CFG_PSA_BIT = 0;

	// ------------------------------------------------------------
	// Instruction word layout
	// ------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int CLS_HI = 13;
	localparam int CLS_LO = 12;
	localparam int SUB_HI = 11;
	localparam int SUB_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int ADDR_HI = 6;
	localparam int BIT_HI = 9;
	localparam int BIT_LO = 7;
	localparam int BOP_HI = 11;
	localparam int BOP_LO = 10;
	localparam int JUMP_BIT = 11;
	localparam int TGT_HI = 10;
	localparam int LIT_HI = 7;

	// ------------------------------------------------------------
	// Opcode encodings
	// ------------------------------------------------------------
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_CTRL = 2'h2;
	localparam logic [1:0] CLS_LIT = 2'h3;
	localparam logic [3:0] SUB_MISC = 4'h0;
	localparam logic [3:0] SUB_CLR = 4'h1;
	localparam logic [3:0] SUB_SUB = 4'h2;
	localparam logic [3:0] SUB_DEC = 4'h3;
	localparam logic [3:0] SUB_IOR = 4'h4;
	localparam logic [3:0] SUB_AND = 4'h5;
	localparam logic [3:0] SUB_XOR = 4'h6;
	localparam logic [3:0] SUB_ADD = 4'h7;
	localparam logic [3:0] SUB_MOV = 4'h8;
	localparam logic [3:0] SUB_COM = 4'h9;
	localparam logic [3:0] SUB_INC = 4'hA;
	localparam logic [3:0] SUB_DECSZ = 4'hB;
	localparam logic [3:0] SUB_RRC = 4'hC;
	localparam logic [3:0] SUB_RLC = 4'hD;
	localparam logic [3:0] SUB_SWAP = 4'hE;
	localparam logic [3:0] SUB_INCSZ = 4'hF;
	localparam logic [1:0] BOP_CLR = 2'h0;
	localparam logic [1:0] BOP_SET = 2'h1;
	localparam logic [1:0] BOP_TSC = 2'h2;
	localparam logic [1:0] BOP_TSS = 2'h3;
	localparam logic [3:0] LIT_IOR = 4'h8;
	localparam logic [3:0] LIT_AND = 4'h9;
	localparam logic [3:0] LIT_XOR = 4'hA;
	localparam logic [1:0] LIT_MOVE = 2'h0;
	localparam logic [1:0] LIT_RET = 2'h1;
	localparam logic [2:0] LIT_SUB = 3'h6;
	localparam logic [2:0] LIT_ADD = 3'h7;
	localparam logic [7:0] LOW_RETURN = 8'h08;
	localparam logic [7:0] LOW_IRET = 8'h09;
	localparam logic [7:0] LOW_WDCLR = 8'h64;
	localparam logic [7:0] LOW_STANDBY = 8'h63;

	// ------------------------------------------------------------
	// Flag masks, status bits, timing, special addresses
	// ------------------------------------------------------------
	localparam logic [2:0] FLAGS_NONE = 3'h0;
	localparam logic [2:0] FLAGS_Z = 3'h1;
	localparam logic [2:0] FLAGS_C = 3'h4;
	localparam logic [2:0] FLAGS_CDZ = 3'h7;
	localparam int STAT_PD = 3;
	localparam int STAT_TO = 4;
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [6:0] ADDR_TIMER0 = 7'h01;
	localparam logic [6:0] ADDR_PORT_A = 7'h05;
	localparam logic [6:0] ADDR_PORT_B = 7'h06;

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD_WORK_TO_FILE, OP_SUB_WORK_FROM_FILE, OP_AND_WORK_FILE,
		OP_OR_WORK_FILE, OP_XOR_WORK_FILE, OP_COMPLEMENT_FILE, OP_MOVE_FILE,
		OP_STORE_WORK_TO_FILE, OP_CLEAR_FILE, OP_INCREMENT_FILE,
		OP_DECREMENT_FILE, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
		OP_SWAP_NIBBLES, OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
		OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_SKIP_CLEAR, OP_TEST_SKIP_SET,
		OP_ADD_LITERAL, OP_SUB_FROM_LITERAL, OP_OR_LITERAL, OP_AND_LITERAL,
		OP_XOR_LITERAL, OP_LOAD_LITERAL, OP_CALL, OP_JUMP_ABSOLUTE,
		OP_RETURN, OP_INTERRUPT_RETURN, OP_RETURN_WITH_LITERAL,
		OP_WATCHDOG_CLEAR, OP_STANDBY
	} mid_op_t;

endpackage

// >>> dv/mcu_instruction_decoder_tb_top.sv
// Self-checking bench for the instruction decoder core
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decoder_tb_top;
	// ------------------------------------------------------------
	// Clock, stimulus signals and design
	// ------------------------------------------------------------
	logic clk = 0, rst_b = 0, avRead = 0, avWrite = 0, wakeEvent = 0;
	logic [3:0] avAddress = 4'h0;
	logic [31:0] avWritedata = 32'h0, avReaddata, rs = 32'h0000_8317, rd;
	logic avWaitrequest, execute, busy, nopCycle, destFile, prescalerClear, watchdogClear;
	logic postscalerClear, timeoutFlag, powerdownFlag, oscStop;
	logic [1:0] qPhase;
	logic [2:0] flagMask, bitNum;
	logic [6:0] fileAddr;
	logic [7:0] literal, operand, fileData, portPins;
	logic [10:0] target;
	logic [13:0] w;
	mid_pkg::mid_op_t aluOp;
	int mismatches = 0, cmpCount = 0, k;
	always #50 clk = ~clk;
	mid_core dut_u (
		.clk(clk), .rst_b(rst_b), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
		.fileData(fileData), .portPins(portPins), .wakeEvent(wakeEvent), .execute(execute),
		.busy(busy), .qPhase(qPhase), .nopCycle(nopCycle), .aluOp(aluOp),
		.flagMask(flagMask), .fileAddr(fileAddr), .destFile(destFile), .bitNum(bitNum),
		.literal(literal), .target(target), .operand(operand),
		.prescalerClear(prescalerClear), .watchdogClear(watchdogClear),
		.postscalerClear(postscalerClear), .timeoutFlag(timeoutFlag),
		.powerdownFlag(powerdownFlag), .oscStop(oscStop)
	);
	mid_file_model model_u (
		.fileAddr(fileAddr),
		.fileData(fileData),
		.portPins(portPins)
	);

	// Compare and count; a mismatch is reported at once
	task automatic check(input string nm, input logic [31:0] seen, exp);
		cmpCount++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	// Flag masks {C,DC,Z} per sub-code, three bits each, byte and literal classes
	function automatic logic [2:0] fmExp(input logic [13:0] w);
		logic [47:0] t;
		t = w[13] ? 48'hFFF049000000 : 48'h024049E493C8;
		return (w[12] == w[13]) ? t[w[11:8] * 3 +: 3] : 3'h0;
	endfunction

	// One when the word takes the extra no-op cycle
	function automatic int nopExp(input logic [13:0] w, input logic [7:0] v);
		case (w[13:12])
			2'h2: return 1;
			2'h3: return int'(w[11:10] == 2'h1);
			2'h1: return int'(w[11] && v[w[9:7]] == w[10]);
			default: return int'((w[11:8] == 4'hB && v == 8'h01) ||
				(w[11:8] == 4'hF && v == 8'hFF) || w[11:1] == 11'h004);
		endcase
	endfunction

	// Operation expected for a word, straight from the encoding tables
	function automatic logic [5:0] opExp(input logic [13:0] w);
		logic [5:0] b [16];
		b = '{mid_pkg::OP_NOP, mid_pkg::OP_CLEAR_FILE, mid_pkg::OP_SUB_WORK_FROM_FILE,
			mid_pkg::OP_DECREMENT_FILE, mid_pkg::OP_OR_WORK_FILE, mid_pkg::OP_AND_WORK_FILE,
			mid_pkg::OP_XOR_WORK_FILE, mid_pkg::OP_ADD_WORK_TO_FILE, mid_pkg::OP_MOVE_FILE,
			mid_pkg::OP_COMPLEMENT_FILE, mid_pkg::OP_INCREMENT_FILE,
			mid_pkg::OP_DECREMENT_SKIP_ZERO, mid_pkg::OP_ROTATE_RIGHT_CARRY,
			mid_pkg::OP_ROTATE_LEFT_CARRY, mid_pkg::OP_SWAP_NIBBLES,
			mid_pkg::OP_INCREMENT_SKIP_ZERO};
		case (w[13:12])
			2'h1: begin
				if (w[11]) return w[10] ? mid_pkg::OP_TEST_SKIP_SET : mid_pkg::OP_TEST_SKIP_CLEAR;
				return w[10] ? mid_pkg::OP_BIT_SET : mid_pkg::OP_BIT_CLEAR;
			end
			2'h2: return w[11] ? mid_pkg::OP_JUMP_ABSOLUTE : mid_pkg::OP_CALL;
			2'h3: begin
				case (w[11:8])
					4'h0, 4'h1, 4'h2, 4'h3: return mid_pkg::OP_LOAD_LITERAL;
					4'h4, 4'h5, 4'h6, 4'h7: return mid_pkg::OP_RETURN_WITH_LITERAL;
					4'h8: return mid_pkg::OP_OR_LITERAL;
					4'h9: return mid_pkg::OP_AND_LITERAL;
					4'hA: return mid_pkg::OP_XOR_LITERAL;
					4'hB: return mid_pkg::OP_NOP;
					4'hC, 4'hD: return mid_pkg::OP_SUB_FROM_LITERAL;
					default: return mid_pkg::OP_ADD_LITERAL;
				endcase
			end
			default: begin
				if (w[11:8] != 4'h0) return b[w[11:8]];
				if (w[7]) return mid_pkg::OP_STORE_WORK_TO_FILE;
				case (w[7:0])
					8'h08: return mid_pkg::OP_RETURN;
					8'h09: return mid_pkg::OP_INTERRUPT_RETURN;
					8'h64: return mid_pkg::OP_WATCHDOG_CLEAR;
					8'h63: return mid_pkg::OP_STANDBY;
					default: return mid_pkg::OP_NOP;
				endcase
			end
		endcase
	endfunction

	// Avalon access: request held until the rising edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		avRead <= !wr;
		avWrite <= wr;
		avAddress <= a;
		avWritedata <= d;
		do begin
			@(posedge clk);
			n++;
			if (n > 300) begin
				mismatches++;
				report_and_stop();
			end
		end while (avWaitrequest !== 1'b0);
		// Values read here are those the slave presents at this very edge
		rd = avReaddata;
		avRead <= 0;
		avWrite <= 0;
	endtask

	// Issue one word, check its fields, pulses, operand and cycle count
	task automatic run(input logic [13:0] w, input logic [2:0] pulse);
		logic [7:0] v;
		logic [29:0] f;
		int n = 1, nops = 0;
		v = (w[6:0] == 7'h05 || w[6:0] == 7'h06) ? 8'h0F : {w[6], w[6:0]} ^ 8'h3C;
		f = {w[6:0], w[7], w[9:7], w[7:0], w[10:0]};
		bus(1, mid_pkg::OFF_INSTR, {18'h0, w});
		@(negedge clk);
		check("execute", execute, 1);
		check("fields", {fileAddr, destFile, bitNum, literal, target}, f);
		check("flags", flagMask, fmExp(w));
		check("op", aluOp, opExp(w));
		check("pulses", {prescalerClear, watchdogClear, postscalerClear}, pulse);
		@(negedge clk);
		check("operand", operand, v);
		while (busy === 1'b1 && n < 40) begin
			check("phase", qPhase, n % 4);
			nops += nopCycle;
			n++;
			@(negedge clk);
		end
		check("nop cycles", nops, 4 * nopExp(w, v));
		check("busy cycles", n, 4 + 4 * nopExp(w, v));
		$display("word %h done", w);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		bus(0, 4'h2, 32'h0);
		check("unmapped", rd, 0);
		// Random words; addresses steered so skips and port reads occur
		for (k = 0; k < 60; k++) begin
			rs = xs(rs);
			w = rs[13:0];
			if (rs[16]) w[6:0] = rs[17] ? 7'h3D : 7'h43;
			if (rs[18]) w[6:0] = 7'h05;
			if (w[13:8] == 6'h0) w[13:8] = 6'h07;
			run(w, 3'h0);
		end
		run(14'h0008, 3'h0);
		run(14'h0009, 3'h0);
		run(14'h0064, 3'h3);
		check("wd flags", {timeoutFlag, powerdownFlag}, 2'h3);
		bus(1, mid_pkg::OFF_CONFIG, 32'h0);
		run(14'h0081, 3'h4);
		run(14'h0063, 3'h2);
		check("standby", {timeoutFlag, powerdownFlag, oscStop}, 3'h5);
		@(posedge clk);
		wakeEvent <= 1;
		@(posedge clk);
		wakeEvent <= 0;
		bus(0, mid_pkg::OFF_STATUS, 32'h0);
		check("status", rd[5:3], 3'h2);
		// A watchdog clear after standby must bring the powerdown flag back
		run(14'h0064, 3'h2);
		check("wd after standby", {timeoutFlag, powerdownFlag}, 2'h3);
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> dv/mid_file_model.sv
// Register file read port and port pins that face the decoder core
`timescale 1ns/1ps
`default_nettype none
module mid_file_model (
	input wire logic [6:0] fileAddr,
	output logic [7:0] fileData,
	output logic [7:0] portPins
);
	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Fixed contents let the bench predict skips: 0x3D holds 01, 0x43 holds FF
	assign fileData = {fileAddr[6], fileAddr} ^ 8'h3C;
	assign portPins = 8'h0F; // Differs from memory so a latch read would show
endmodule
`default_nettype wire

// >>> logic/mid_core.sv
// Instruction decoder and cycle sequencer with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module mid_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	output logic [31:0] avReaddata,
	output logic avWaitrequest,
	input wire logic [7:0] fileData,
	input wire logic [7:0] portPins,
	input wire logic wakeEvent,
	output logic execute,
	output logic busy,
	output logic [1:0] qPhase,
	output logic nopCycle,
	output var mid_pkg::mid_op_t aluOp,
	output logic [2:0] flagMask,
	output logic [6:0] fileAddr,
	output logic destFile,
	output logic [2:0] bitNum,
	output logic [7:0] literal,
	output logic [10:0] target,
	output logic [7:0] operand,
	output logic prescalerClear,
	output logic watchdogClear,
	output logic postscalerClear,
	output logic timeoutFlag,
	output logic powerdownFlag,
	output logic oscStop
);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// Internal state
	// ------------------------------------------------------------
	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	logic psaToWatchdog;
	logic [13:0] instrReg;
	logic pcChange;
	logic writesTimer;
	logic start;
	logic grant;
	logic takeTwo;
	logic skipTrue;
	logic portSource;
	logic [7:0] next_incr;
	logic [7:0] next_decr;
	logic [31:0] next_readdata;
	mid_pkg::mid_op_t decOp;
	logic [2:0] decFlags;
	logic decChangesPc;
	logic decWritesFile;

	// ------------------------------------------------------------
	// Decode of the word being written
	// ------------------------------------------------------------
	// Decoding the bus word lets every output load from a flop at start
	mid_decode decode (
		.instr(avWritedata[mid_pkg::INSTR_W-1:0]),
		.op(decOp),
		.flagMask(decFlags),
		.changesPc(decChangesPc),
		.writesFile(decWritesFile)
	);

	// ------------------------------------------------------------
	// Avalon slave
	// ------------------------------------------------------------
	// An instruction write waits while one executes; that is the back-pressure
	assign grant = (avRead | avWrite) & avWaitrequest
		& ~(avWrite & (avAddress == mid_pkg::OFF_INSTR) & busy);
	assign start = avWrite & ~avWaitrequest & (avAddress == mid_pkg::OFF_INSTR);

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avAddress)
			mid_pkg::OFF_INSTR: next_readdata[13:0] = instrReg;
			mid_pkg::OFF_CONFIG: next_readdata[mid_pkg::CFG_PSA_BIT] = psaToWatchdog;
			mid_pkg::OFF_FIELDS: next_readdata = {2'h0, aluOp, literal, 5'h00,
				bitNum, destFile, fileAddr};
			mid_pkg::OFF_STATUS: next_readdata = {21'h000000, flagMask, 2'h0,
				oscStop, timeoutFlag, powerdownFlag, 1'b0, nopCycle, busy};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// One wait cycle on every access, longer for an instruction while busy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avWaitrequest <= 1'b1;
			avReaddata <= 32'h0000_0000;
		end else begin
			avWaitrequest <= ~grant;
			if (grant) begin
				avReaddata <= next_readdata;
			end
		end
	end

	// Prescaler assignment bit, the one software-steered control
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			psaToWatchdog <= mid_pkg::CFG_PSA_RESET;
		end else if (avWrite && !avWaitrequest && avAddress == mid_pkg::OFF_CONFIG) begin
			psaToWatchdog <= avWritedata[mid_pkg::CFG_PSA_BIT];
		end
	end

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta <= 8'h00;
			pinSync <= 8'h00;
		end else begin
			pinMeta <= portPins;
			pinSync <= pinMeta;
		end
	end

	// ------------------------------------------------------------
	// Field latch at instruction start
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			instrReg <= 14'h0000;
			aluOp <= mid_pkg::OP_NOP;
			flagMask <= mid_pkg::FLAGS_NONE;
			fileAddr <= 7'h00;
			destFile <= 1'b0;
			bitNum <= 3'h0;
			literal <= 8'h00;
			target <= 11'h000;
			pcChange <= 1'b0;
			writesTimer <= 1'b0;
		end else if (start) begin
			instrReg <= avWritedata[mid_pkg::INSTR_W-1:0];
			aluOp <= decOp;
			flagMask <= decFlags;
			fileAddr <= avWritedata[mid_pkg::ADDR_HI:0];
			destFile <= avWritedata[mid_pkg::DEST_BIT];
			bitNum <= avWritedata[mid_pkg::BIT_HI:mid_pkg::BIT_LO];
			literal <= avWritedata[mid_pkg::LIT_HI:0];
			target <= avWritedata[mid_pkg::TGT_HI:0];
			pcChange <= decChangesPc;
			writesTimer <= decWritesFile
				&& avWritedata[mid_pkg::ADDR_HI:0] == mid_pkg::ADDR_TIMER0;
		end
	end

	// ------------------------------------------------------------
	// Operand capture
	// ------------------------------------------------------------
	// Port registers read back the pins, not the output latch
	assign portSource = (fileAddr == mid_pkg::ADDR_PORT_A)
		|| (fileAddr == mid_pkg::ADDR_PORT_B);

	// The datapath sees fileAddr for one clock before the operand is taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			operand <= 8'h00;
		end else if (execute) begin
			operand <= portSource ? pinSync : fileData;
		end
	end

	// ------------------------------------------------------------
	// Second-cycle decision
	// ------------------------------------------------------------
	assign next_incr = operand + 8'h01;
	assign next_decr = operand - 8'h01;

	always_comb begin
		case (aluOp)
			mid_pkg::OP_DECREMENT_SKIP_ZERO: skipTrue = (next_decr == 8'h00);
			mid_pkg::OP_INCREMENT_SKIP_ZERO: skipTrue = (next_incr == 8'h00);
			mid_pkg::OP_TEST_SKIP_CLEAR: skipTrue = ~operand[bitNum];
			mid_pkg::OP_TEST_SKIP_SET: skipTrue = operand[bitNum];
			default: skipTrue = 1'b0;
		endcase
	end

	// Branches and true skips cost a forced no-op cycle
	assign takeTwo = pcChange | skipTrue;

	// ------------------------------------------------------------
	// Cycle sequencer: four clocks per instruction cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			qPhase <= 2'h0;
			nopCycle <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
			qPhase <= 2'h0;
			nopCycle <= 1'b0;
		end else if (busy) begin
			qPhase <= qPhase + 2'h1;
			if (qPhase == mid_pkg::Q_LAST) begin
				if (!nopCycle && takeTwo) begin
					nopCycle <= 1'b1;
				end else begin
					busy <= 1'b0;
					nopCycle <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Side-effect strobes, one clock wide at start
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			execute <= 1'b0;
			prescalerClear <= 1'b0;
			watchdogClear <= 1'b0;
			postscalerClear <= 1'b0;
		end else begin
			execute <= start;
			// Timer writes clear the prescaler only when the timer owns it
			prescalerClear <= start && decWritesFile && !psaToWatchdog
				&& avWritedata[mid_pkg::ADDR_HI:0] == mid_pkg::ADDR_TIMER0;
			watchdogClear <= start && (decOp == mid_pkg::OP_WATCHDOG_CLEAR
				|| decOp == mid_pkg::OP_STANDBY);
			postscalerClear <= start && psaToWatchdog
				&& (decOp == mid_pkg::OP_WATCHDOG_CLEAR
				|| decOp == mid_pkg::OP_STANDBY);
		end
	end

	// ------------------------------------------------------------
	// Power status flags and oscillator stop
	// ------------------------------------------------------------
	// Both flags come up set; a wake event restarts the oscillator unless a standby or watchdog clear executes in that clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timeoutFlag <= 1'b1;
			powerdownFlag <= 1'b1;
			oscStop <= 1'b0;
		end else if (execute && aluOp == mid_pkg::OP_STANDBY) begin
			powerdownFlag <= 1'b0;
			timeoutFlag <= 1'b1;
			oscStop <= 1'b1;
		end else if (execute && aluOp == mid_pkg::OP_WATCHDOG_CLEAR) begin
			powerdownFlag <= 1'b1;
			timeoutFlag <= 1'b1;
		end else if (wakeEvent) begin
			oscStop <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence sqOneCycle;
		busy[*4] ##1 !busy;
	endsequence

	sequence sqTwoCycles;
		(busy && !nopCycle)[*4] ##1 (busy && nopCycle)[*4] ##1 !busy;
	endsequence

	chk_single_cycle_len: assert property (
		execute && !pcChange && !(aluOp inside {mid_pkg::OP_DECREMENT_SKIP_ZERO,
			mid_pkg::OP_INCREMENT_SKIP_ZERO, mid_pkg::OP_TEST_SKIP_CLEAR,
			mid_pkg::OP_TEST_SKIP_SET}) |-> sqOneCycle)
		else $error("plain instruction did not take four clocks");

	chk_branch_two_cycles: assert property (
		execute && pcChange |-> sqTwoCycles)
		else $error("branch did not take two instruction cycles");

	chk_skip_nop_cycle: assert property (
		busy && qPhase == mid_pkg::Q_LAST && !nopCycle && skipTrue |=> nopCycle[*4])
		else $error("true skip did not add a no-op cycle");

	chk_dest_route: assert property (
		execute && instrReg[mid_pkg::CLS_HI:mid_pkg::CLS_LO] == mid_pkg::CLS_BYTE |->
			destFile == instrReg[mid_pkg::DEST_BIT] ##1 $stable(destFile)[*3])
		else $error("destination select does not follow the word");

	chk_arith_flags: assert property (
		execute && aluOp inside {mid_pkg::OP_ADD_WORK_TO_FILE,
			mid_pkg::OP_SUB_WORK_FROM_FILE, mid_pkg::OP_ADD_LITERAL,
			mid_pkg::OP_SUB_FROM_LITERAL} |-> flagMask == mid_pkg::FLAGS_CDZ)
		else $error("arithmetic op lacks carry, digit carry, zero");

	chk_quiet_flags: assert property (
		execute && aluOp inside {mid_pkg::OP_BIT_CLEAR, mid_pkg::OP_BIT_SET,
			mid_pkg::OP_TEST_SKIP_CLEAR, mid_pkg::OP_TEST_SKIP_SET,
			mid_pkg::OP_SWAP_NIBBLES, mid_pkg::OP_LOAD_LITERAL,
			mid_pkg::OP_DECREMENT_SKIP_ZERO} |-> flagMask == mid_pkg::FLAGS_NONE)
		else $error("flag-free op marks a flag update");

	chk_pin_source: assert property (
		execute && portSource |=> operand == $past(pinSync))
		else $error("port operand not taken from the pins");

	chk_timer_prescaler: assert property (
		execute && writesTimer |-> prescalerClear == !psaToWatchdog)
		else $error("timer write did not clear the prescaler");

	chk_standby_flags: assert property (
		execute && aluOp == mid_pkg::OP_STANDBY |=>
			!powerdownFlag && timeoutFlag && oscStop)
		else $error("standby did not update power flags");

	chk_watchdog_clear: assert property (
		execute && aluOp inside {mid_pkg::OP_WATCHDOG_CLEAR, mid_pkg::OP_STANDBY}
			|-> watchdogClear && postscalerClear == psaToWatchdog)
		else $error("watchdog not cleared by its instructions");

	chk_bus_answer: assert property (
		(avRead || avWrite) && !avWaitrequest |=> avWaitrequest)
		else $error("waitrequest low for more than one cycle");

endmodule
`default_nettype wire

// >>> logic/mid_decode.sv
// Combinational opcode decoder: class, operation, flag mask
`timescale 1ns/1ps
`default_nettype none
module mid_decode (
	input wire logic [13:0] instr,
	output var mid_pkg::mid_op_t op,
	output logic [2:0] flagMask,
	output logic changesPc,
	output logic writesFile
);

	logic [7:0] lowByte;

	assign lowByte = instr[mid_pkg::LIT_HI:0];

	// Don't-care positions are simply never looked at
	always_comb begin
		op = mid_pkg::OP_NOP;
		flagMask = mid_pkg::FLAGS_NONE;
		writesFile = 1'b0;
		unique case (instr[mid_pkg::CLS_HI:mid_pkg::CLS_LO])
			mid_pkg::CLS_BYTE: begin
				writesFile = instr[mid_pkg::DEST_BIT];
				flagMask = mid_pkg::FLAGS_Z;
				unique case (instr[mid_pkg::SUB_HI:mid_pkg::SUB_LO])
					mid_pkg::SUB_MISC: begin
						flagMask = mid_pkg::FLAGS_NONE;
						if (instr[mid_pkg::DEST_BIT]) begin
							op = mid_pkg::OP_STORE_WORK_TO_FILE;
						end else if (lowByte == mid_pkg::LOW_RETURN) begin
							op = mid_pkg::OP_RETURN;
						end else if (lowByte == mid_pkg::LOW_IRET) begin
							op = mid_pkg::OP_INTERRUPT_RETURN;
						end else if (lowByte == mid_pkg::LOW_WDCLR) begin
							op = mid_pkg::OP_WATCHDOG_CLEAR;
						end else if (lowByte == mid_pkg::LOW_STANDBY) begin
							op = mid_pkg::OP_STANDBY;
						end
					end
					mid_pkg::SUB_CLR: op = mid_pkg::OP_CLEAR_FILE;
					mid_pkg::SUB_SUB: begin
						op = mid_pkg::OP_SUB_WORK_FROM_FILE;
						flagMask = mid_pkg::FLAGS_CDZ;
					end
					mid_pkg::SUB_DEC: op = mid_pkg::OP_DECREMENT_FILE;
					mid_pkg::SUB_IOR: op = mid_pkg::OP_OR_WORK_FILE;
					mid_pkg::SUB_AND: op = mid_pkg::OP_AND_WORK_FILE;
					mid_pkg::SUB_XOR: op = mid_pkg::OP_XOR_WORK_FILE;
					mid_pkg::SUB_ADD: begin
						op = mid_pkg::OP_ADD_WORK_TO_FILE;
						flagMask = mid_pkg::FLAGS_CDZ;
					end
					mid_pkg::SUB_MOV: op = mid_pkg::OP_MOVE_FILE;
					mid_pkg::SUB_COM: op = mid_pkg::OP_COMPLEMENT_FILE;
					mid_pkg::SUB_INC: op = mid_pkg::OP_INCREMENT_FILE;
					mid_pkg::SUB_DECSZ: begin
						op = mid_pkg::OP_DECREMENT_SKIP_ZERO;
						flagMask = mid_pkg::FLAGS_NONE;
					end
					mid_pkg::SUB_RRC: begin
						op = mid_pkg::OP_ROTATE_RIGHT_CARRY;
						flagMask = mid_pkg::FLAGS_C;
					end
					mid_pkg::SUB_RLC: begin
						op = mid_pkg::OP_ROTATE_LEFT_CARRY;
						flagMask = mid_pkg::FLAGS_C;
					end
					mid_pkg::SUB_SWAP: begin
						op = mid_pkg::OP_SWAP_NIBBLES;
						flagMask = mid_pkg::FLAGS_NONE;
					end
					mid_pkg::SUB_INCSZ: begin
						op = mid_pkg::OP_INCREMENT_SKIP_ZERO;
						flagMask = mid_pkg::FLAGS_NONE;
					end
				endcase
			end
			mid_pkg::CLS_BIT: begin
				// Bit ops never touch the flags
				unique case (instr[mid_pkg::BOP_HI:mid_pkg::BOP_LO])
					mid_pkg::BOP_CLR: op = mid_pkg::OP_BIT_CLEAR;
					mid_pkg::BOP_SET: op = mid_pkg::OP_BIT_SET;
					mid_pkg::BOP_TSC: op = mid_pkg::OP_TEST_SKIP_CLEAR;
					mid_pkg::BOP_TSS: op = mid_pkg::OP_TEST_SKIP_SET;
				endcase
				writesFile = ~instr[mid_pkg::BOP_HI];
			end
			mid_pkg::CLS_CTRL: begin
				// Bit 11 splits call from jump
				if (instr[mid_pkg::JUMP_BIT]) begin
					op = mid_pkg::OP_JUMP_ABSOLUTE;
				end else begin
					op = mid_pkg::OP_CALL;
				end
			end
			mid_pkg::CLS_LIT: begin
				if (instr[11:10] == mid_pkg::LIT_MOVE) begin
					op = mid_pkg::OP_LOAD_LITERAL;
				end else if (instr[11:10] == mid_pkg::LIT_RET) begin
					op = mid_pkg::OP_RETURN_WITH_LITERAL;
				end else if (instr[11:9] == mid_pkg::LIT_ADD) begin
					op = mid_pkg::OP_ADD_LITERAL;
					flagMask = mid_pkg::FLAGS_CDZ;
				end else if (instr[11:9] == mid_pkg::LIT_SUB) begin
					op = mid_pkg::OP_SUB_FROM_LITERAL;
					flagMask = mid_pkg::FLAGS_CDZ;
				end else if (instr[11:8] == mid_pkg::LIT_IOR) begin
					op = mid_pkg::OP_OR_LITERAL;
					flagMask = mid_pkg::FLAGS_Z;
				end else if (instr[11:8] == mid_pkg::LIT_AND) begin
					op = mid_pkg::OP_AND_LITERAL;
					flagMask = mid_pkg::FLAGS_Z;
				end else if (instr[11:8] == mid_pkg::LIT_XOR) begin
					op = mid_pkg::OP_XOR_LITERAL;
					flagMask = mid_pkg::FLAGS_Z;
				end
			end
		endcase
	end

	// Jumps, calls and returns all load the program counter
	assign changesPc = (op inside {mid_pkg::OP_CALL, mid_pkg::OP_JUMP_ABSOLUTE,
		mid_pkg::OP_RETURN, mid_pkg::OP_INTERRUPT_RETURN,
		mid_pkg::OP_RETURN_WITH_LITERAL});

endmodule
`default_nettype wire
